// file: ardc_map.svh
`ifndef ARDC_MAP_SVH
`define ARDC_MAP_SVH

// register indices; byte address is four times the index
`define ARDC_IDX_PRIMARY_TX      6'h0d
`define ARDC_IDX_SECONDARY_IF    6'h0e
`define ARDC_IDX_DAC_INPUT       6'h0f
`define ARDC_IDX_DAC_MIX         6'h10
`define ARDC_IDX_DAC_DEEMPH      6'h11
`define ARDC_IDX_DAC1_SOURCE     6'h0c
`define ARDC_IDX_STATUS          6'h20

// reset values
`define ARDC_RST_PRIMARY_TX      9'h08a
`define ARDC_RST_SECONDARY_IF    9'h00a
`define ARDC_RST_DAC_INPUT       9'h0e4
`define ARDC_RST_DAC_MIX         9'h009
`define ARDC_RST_DAC_DEEMPH      9'h000
`define ARDC_RST_DAC1_SOURCE     9'h180

// field positions shared by both audio interfaces
`define ARDC_F_FMT               1:0
`define ARDC_F_WL                3:2
`define ARDC_B_FRAME             4
`define ARDC_B_BITCLK            5
`define ARDC_B_ENABLE            6
`define ARDC_F_SRC               8:7
// dac fields
`define ARDC_B_RX_MODE           8
`define ARDC_F_MIX               3:0
`define ARDC_F_ZSRC              6:4
`define ARDC_B_AUTOMUTE          7
`define ARDC_F_DEEMPH            3:0
`define ARDC_B_DEEMPH_ALL        4
`define ARDC_F_DAC1_SRC          8:7

// codes
`define ARDC_FMT_DSP             2'h3
`define ARDC_SRC_SPDIF           2'h0
`define ARDC_ZSRC_ALL            3'h0
`define ARDC_ZSRC_DAC4           3'h4
`define ARDC_RESP_OKAY           2'h0
`define ARDC_RESP_SLVERR         2'h2

`endif

// file: ardc_pkg.sv
package ardc_pkg;

	typedef struct packed {
		logic [1:0] format_sel;
		logic [1:0] word_len;
		logic [5:0] word_bits;
		logic       frame_invert;
		logic       dsp_mode_b;
		logic       bitclk_invert;
		logic       active;
		logic [1:0] source;
	} ardc_aif_cfg_s;

	typedef struct packed {
		logic [1:0] dac1_input_sel;
		logic [1:0] dac2_input_sel;
		logic [1:0] dac3_input_sel;
		logic [1:0] dac4_input_sel;
		logic [1:0] dac1_source_sel;
		logic       spdif_to_dac_mode;
		logic       osr_from_spdif;
		logic       dacs_from_primary;
		logic [2:0] dac_powerdown;
	} ardc_dac_route_s;

endpackage : ardc_pkg

// file: ardc_aif_cfg.sv
`timescale 1ns/1ps
`include "ardc_map.svh"

module ardc_aif_cfg (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic [8:0]            raw,
	input  wire logic                  has_enable,
	output ardc_pkg::ardc_aif_cfg_s    cfg
);

	logic is_dsp;
	assign is_dsp = (raw[`ARDC_F_FMT] == `ARDC_FMT_DSP);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg <= '0;
		end else begin
			cfg.format_sel    <= raw[`ARDC_F_FMT];
			cfg.word_len      <= raw[`ARDC_F_WL];
			unique case (raw[`ARDC_F_WL])
				2'h0: cfg.word_bits <= 6'h10;
				2'h1: cfg.word_bits <= 6'h14;
				2'h2: cfg.word_bits <= 6'h18;
				2'h3: cfg.word_bits <= 6'h20;
			endcase
			// one bit, two meanings by format
			cfg.frame_invert  <= raw[`ARDC_B_FRAME] & ~is_dsp;
			cfg.dsp_mode_b    <= raw[`ARDC_B_FRAME] & is_dsp;
			cfg.bitclk_invert <= raw[`ARDC_B_BITCLK];
			cfg.active        <= ~has_enable | raw[`ARDC_B_ENABLE];
			cfg.source        <= raw[`ARDC_F_SRC];
		end
	end

endmodule : ardc_aif_cfg

// file: ardc_mixer.sv
`timescale 1ns/1ps

module ardc_mixer #(
	parameter int WIDTH = 24
) (
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic [3:0]               mix_code,
	input  wire logic                     in_valid,
	input  wire logic signed [WIDTH-1:0]  in_left,
	input  wire logic signed [WIDTH-1:0]  in_right,
	output logic                          out_valid,
	output logic signed [WIDTH-1:0]       out_left,
	output logic signed [WIDTH-1:0]       out_right
);

	if (WIDTH < 2) begin : g_bad_width
		$error("ardc_mixer: WIDTH below 2");
	end

	logic signed [WIDTH:0] sum;
	logic signed [WIDTH-1:0] avg;
	assign sum = in_left + in_right;
	// full-width sum first so the average cannot overflow
	assign avg = sum[WIDTH:1];

	function automatic logic signed [WIDTH-1:0] pick(input logic [1:0] c);
		unique case (c)
			2'h0: pick = '0;
			2'h1: pick = in_left;
			2'h2: pick = in_right;
			2'h3: pick = avg;
		endcase
	endfunction : pick

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_left  <= '0;
			out_right <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_left  <= pick(mix_code[1:0]);
				out_right <= pick(mix_code[3:2]);
			end
		end
	end

endmodule : ardc_mixer

// file: ardc_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "ardc_map.svh"

// Operation
// - primary tx format code, resets to I2S
// - primary tx word length code, resets 24
// - bit 4 inverts frame or picks DSP B
// - bit 5 inverts bit clock, resets off
// - primary tx source code, resets ADC
// - secondary interface active only when enabled
// - secondary format and length share primary codes
// - secondary tx source code, resets S/PDIF
// - four DAC input selectors, reset one-to-one
// - S/PDIF to DAC1 mode powers or reroutes
// - three-bit zero flag source, rest force zero
// - automute on infinite zero when bit set
// - per-DAC de-emphasis enable bits
// - global de-emphasis bit enables every DAC
// - DAC1 source code, 00 selects S/PDIF
module ardc_top #(
	parameter int ADDR_W   = 8,
	parameter int SAMPLE_W = 24
) (
	input  wire logic                       sys_clk,
	input  wire logic                       sys_rst,
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [3:0]                 dac_zero,
	input  wire logic                       sample_valid,
	input  wire logic signed [SAMPLE_W-1:0] sample_left,
	input  wire logic signed [SAMPLE_W-1:0] sample_right,
	output ardc_pkg::ardc_aif_cfg_s         primary_cfg,
	output ardc_pkg::ardc_aif_cfg_s         secondary_cfg,
	output ardc_pkg::ardc_dac_route_s       dac_route,
	output logic                            mix_valid,
	output logic signed [SAMPLE_W-1:0]      mix_left,
	output logic signed [SAMPLE_W-1:0]      mix_right,
	output logic                            zero_flag_out,
	output logic [3:0]                      dac_automute,
	output logic [3:0]                      dac_deemph_en
);

	if (ADDR_W < 8) begin : g_bad_addr_w
		$error("ardc_top: ADDR_W below 8");
	end

	logic [8:0] primary_tx_format;
	logic [8:0] secondary_if_format;
	logic [8:0] dac_input_select;
	logic [8:0] dac_mix_zero_flag;
	logic [8:0] dac_deemphasis;
	logic [8:0] dac1_source_ctrl;

	// ---------------- write channel ----------------
	logic       aw_full;
	logic       w_full;
	logic [5:0] aw_idx;
	logic [8:0] w_data;
	logic [1:0] w_strb;
	logic       aw_take;
	logic       w_take;
	logic       do_write;
	logic       next_aw_full;
	logic       next_w_full;
	logic       wr_hit;

	assign aw_take  = s_axi_awvalid & s_axi_awready;
	assign w_take   = s_axi_wvalid & s_axi_wready;
	// one write in flight: the next waits for its response
	assign do_write = aw_full & w_full & ~s_axi_bvalid;
	assign next_aw_full = ~do_write & (aw_full | aw_take);
	assign next_w_full  = ~do_write & (w_full | w_take);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_idx        <= 6'h00;
			w_data        <= 9'h000;
			w_strb        <= 2'h0;
		end else begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			s_axi_awready <= ~next_aw_full;
			s_axi_wready  <= ~next_w_full;
			if (aw_take) begin
				aw_idx <= s_axi_awaddr[7:2];
			end
			if (w_take) begin
				w_data <= s_axi_wdata[8:0];
				w_strb <= s_axi_wstrb[1:0];
			end
		end
	end

	always_comb begin
		unique case (aw_idx)
			`ARDC_IDX_PRIMARY_TX,
			`ARDC_IDX_SECONDARY_IF,
			`ARDC_IDX_DAC_INPUT,
			`ARDC_IDX_DAC_MIX,
			`ARDC_IDX_DAC_DEEMPH,
			`ARDC_IDX_DAC1_SOURCE: wr_hit = 1'b1;
			default:               wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ARDC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `ARDC_RESP_OKAY : `ARDC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [8:0] merge(input logic [8:0] old_v);
		merge = {w_strb[1] ? w_data[8] : old_v[8],
			w_strb[0] ? w_data[7:0] : old_v[7:0]};
	endfunction : merge

	// ---------------- register file ----------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			primary_tx_format   <= `ARDC_RST_PRIMARY_TX;
			secondary_if_format <= `ARDC_RST_SECONDARY_IF;
			dac_input_select    <= `ARDC_RST_DAC_INPUT;
			dac_mix_zero_flag   <= `ARDC_RST_DAC_MIX;
			dac_deemphasis      <= `ARDC_RST_DAC_DEEMPH;
			dac1_source_ctrl    <= `ARDC_RST_DAC1_SOURCE;
		end else if (do_write) begin
			unique case (aw_idx)
				`ARDC_IDX_PRIMARY_TX: begin
					// bit 6 unused here, kept at zero
					primary_tx_format <= merge(primary_tx_format) & 9'h1bf;
				end
				`ARDC_IDX_SECONDARY_IF: begin
					secondary_if_format <= merge(secondary_if_format);
				end
				`ARDC_IDX_DAC_INPUT: begin
					dac_input_select <= merge(dac_input_select);
				end
				`ARDC_IDX_DAC_MIX: begin
					dac_mix_zero_flag <= merge(dac_mix_zero_flag) & 9'h0ff;
				end
				`ARDC_IDX_DAC_DEEMPH: begin
					dac_deemphasis <= merge(dac_deemphasis) & 9'h01f;
				end
				`ARDC_IDX_DAC1_SOURCE: begin
					dac1_source_ctrl <= merge(dac1_source_ctrl) & 9'h180;
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------- read channel ----------------
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [5:0]  ar_idx;
	assign ar_idx = s_axi_araddr[7:2];

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (ar_idx)
			`ARDC_IDX_PRIMARY_TX:   rd_word[8:0] = primary_tx_format;
			`ARDC_IDX_SECONDARY_IF: rd_word[8:0] = secondary_if_format;
			`ARDC_IDX_DAC_INPUT:    rd_word[8:0] = dac_input_select;
			`ARDC_IDX_DAC_MIX:      rd_word[8:0] = dac_mix_zero_flag;
			`ARDC_IDX_DAC_DEEMPH:   rd_word[8:0] = dac_deemphasis;
			`ARDC_IDX_DAC1_SOURCE:  rd_word[8:0] = dac1_source_ctrl;
			`ARDC_IDX_STATUS: begin
				rd_word[8:0] = {dac_route.dac_powerdown, dac_automute,
					secondary_cfg.active, zero_flag_out};
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ARDC_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? `ARDC_RESP_OKAY : `ARDC_RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------- audio interface setup ----------------
	ardc_aif_cfg u_primary (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.raw        (primary_tx_format),
		.has_enable (1'b0),
		.cfg        (primary_cfg)
	);

	ardc_aif_cfg u_secondary (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.raw        (secondary_if_format),
		.has_enable (1'b1),
		.cfg        (secondary_cfg)
	);

	// ---------------- dac routing ----------------
	logic spdif_feed;
	logic rx_mode;
	assign spdif_feed = dac1_source_ctrl[`ARDC_F_DAC1_SRC] == `ARDC_SRC_SPDIF;
	assign rx_mode    = dac_input_select[`ARDC_B_RX_MODE];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_route <= '0;
		end else begin
			dac_route.dac1_input_sel    <= dac_input_select[1:0];
			dac_route.dac2_input_sel    <= dac_input_select[3:2];
			dac_route.dac3_input_sel    <= dac_input_select[5:4];
			dac_route.dac4_input_sel    <= dac_input_select[7:6];
			dac_route.dac1_source_sel   <=
				dac1_source_ctrl[`ARDC_F_DAC1_SRC];
			dac_route.spdif_to_dac_mode <= rx_mode;
			// powering down only applies while S/PDIF feeds DAC1
			dac_route.osr_from_spdif    <= spdif_feed & ~rx_mode;
			dac_route.dac_powerdown     <= {3{spdif_feed & ~rx_mode}};
			dac_route.dacs_from_primary <= spdif_feed & rx_mode;
		end
	end

	// ---------------- zero flag, automute, de-emphasis ----------------
	logic [2:0] zsrc;
	logic       izd_on;
	assign zsrc   = dac_mix_zero_flag[`ARDC_F_ZSRC];
	assign izd_on = dac_mix_zero_flag[`ARDC_B_AUTOMUTE];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			zero_flag_out <= 1'b0;
		end else if (zsrc == `ARDC_ZSRC_ALL) begin
			zero_flag_out <= &dac_zero;
		end else if (zsrc <= `ARDC_ZSRC_DAC4) begin
			zero_flag_out <= dac_zero[zsrc[1:0] - 2'h1];
		end else begin
			zero_flag_out <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_automute <= 4'h0;
		end else begin
			dac_automute <= dac_zero & {4{izd_on}};
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_deemph_en <= 4'h0;
		end else begin
			dac_deemph_en <= dac_deemphasis[`ARDC_F_DEEMPH]
				| {4{dac_deemphasis[`ARDC_B_DEEMPH_ALL]}};
		end
	end

	ardc_mixer #(
		.WIDTH (SAMPLE_W)
	) u_mixer (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.mix_code  (dac_mix_zero_flag[`ARDC_F_MIX]),
		.in_valid  (sample_valid),
		.in_left   (sample_left),
		.in_right  (sample_right),
		.out_valid (mix_valid),
		.out_left  (mix_left),
		.out_right (mix_right)
	);

	// ---------------- checks ----------------
	property p_ptx_fmt;
		@(posedge sys_clk) disable iff (sys_rst)
		// first edge after release still shows the reset outputs
		!$past(sys_rst)
		|-> primary_cfg.format_sel == $past(primary_tx_format[1:0]);
	endproperty
	a_ptx_fmt: assert property (p_ptx_fmt)
		else $error("primary format not followed");

	property p_ptx_wl;
		@(posedge sys_clk) disable iff (sys_rst)
		primary_tx_format[3:2] == 2'h3 |=> primary_cfg.word_bits == 6'h20;
	endproperty
	a_ptx_wl: assert property (p_ptx_wl)
		else $error("32-bit word length not decoded");

	property p_dsp_b;
		@(posedge sys_clk) disable iff (sys_rst)
		(primary_tx_format[1:0] == 2'h3 && primary_tx_format[4])
		|=> primary_cfg.dsp_mode_b && !primary_cfg.frame_invert;
	endproperty
	a_dsp_b: assert property (p_dsp_b)
		else $error("dsp mode b wrong");

	property p_bclk;
		@(posedge sys_clk) disable iff (sys_rst)
		##1 secondary_cfg.bitclk_invert == $past(secondary_if_format[5]);
	endproperty
	a_bclk: assert property (p_bclk)
		else $error("bit clock polarity wrong");

	property p_src;
		@(posedge sys_clk) disable iff (sys_rst)
		!$past(sys_rst)
		|-> primary_cfg.source == $past(primary_tx_format[8:7]);
	endproperty
	a_src: assert property (p_src)
		else $error("primary source wrong");

	property p_sec_off;
		@(posedge sys_clk) disable iff (sys_rst)
		!secondary_if_format[6] |=> !secondary_cfg.active;
	endproperty
	a_sec_off: assert property (p_sec_off)
		else $error("secondary active while disabled");

	property p_pd;
		@(posedge sys_clk) disable iff (sys_rst)
		(spdif_feed && !rx_mode) |=> dac_route.dac_powerdown == 3'h7;
	endproperty
	a_pd: assert property (p_pd)
		else $error("dacs 2-4 not powered down");

	property p_no_pd;
		@(posedge sys_clk) disable iff (sys_rst)
		!spdif_feed |=> dac_route.dac_powerdown == 3'h0
			&& !dac_route.dacs_from_primary;
	endproperty
	a_no_pd: assert property (p_no_pd)
		else $error("powerdown without S/PDIF source");

	property p_mute;
		@(posedge sys_clk) disable iff (sys_rst)
		(sample_valid && dac_mix_zero_flag[3:0] == 4'h0)
		|=> mix_valid && mix_left == 0 && mix_right == 0;
	endproperty
	a_mute: assert property (p_mute)
		else $error("mute code did not mute");

	property p_zf;
		@(posedge sys_clk) disable iff (sys_rst)
		zsrc > `ARDC_ZSRC_DAC4 |=> !zero_flag_out;
	endproperty
	a_zf: assert property (p_zf)
		else $error("zero flag not forced low");

	property p_am;
		@(posedge sys_clk) disable iff (sys_rst)
		!izd_on |=> dac_automute == 4'h0;
	endproperty
	a_am: assert property (p_am)
		else $error("automute while disabled");

	property p_de;
		@(posedge sys_clk) disable iff (sys_rst)
		dac_deemphasis[4] |=> dac_deemph_en == 4'hf;
	endproperty
	a_de: assert property (p_de)
		else $error("global de-emphasis ignored");

endmodule : ardc_top

// file: ardc_tb.sv
`timescale 1ns/1ps
`include "ardc_map.svh"

module testbench;
	logic                      sys_clk;
	logic                      sys_rst;
	logic [7:0]                awa, ara;
	logic                      awv, wv, bre, arv, rre, sv;
	logic [31:0]               wd, rd;
	logic [3:0]                dz, am, de;
	logic signed [23:0]        sl, sr, ml, mr;
	logic                      awr, wr, bv, arr, rv, mv, zf;
	logic [1:0]                br, rr;
	ardc_pkg::ardc_aif_cfg_s   pc, sc;
	ardc_pkg::ardc_dac_route_s dr;
	int                        failures, comparisons, cycles;

	ardc_top #(.ADDR_W(8), .SAMPLE_W(24)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .dac_zero(dz),
		.sample_valid(sv), .sample_left(sl), .sample_right(sr),
		.primary_cfg(pc), .secondary_cfg(sc), .dac_route(dr),
		.mix_valid(mv), .mix_left(ml), .mix_right(mr),
		.zero_flag_out(zf), .dac_automute(am), .dac_deemph_en(de)
	);

	always #5 sys_clk = ~sys_clk;

	task summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// a hung handshake ends here instead of spinning forever
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	task check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	function logic [7:0] ba(input logic [5:0] idx);
		return {idx, 2'h0};
	endfunction : ba

	task axi_wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] resp);
		logic done;
		done = 0;
		@(posedge sys_clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		while (!done) begin
			@(posedge sys_clk);
			if (awv && awr) awv <= 0;
			if (wv && wr) wv <= 0;
			if (bv) begin
				resp = br;
				bre <= 0;
				done = 1;
			end
		end
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] resp);
		logic done;
		done = 0;
		@(posedge sys_clk);
		ara <= a;
		arv <= 1;
		rre <= 1;
		while (!done) begin
			@(posedge sys_clk);
			if (arv && arr) arv <= 0;
			if (rv) begin
				d = rd;
				resp = rr;
				rre <= 0;
				done = 1;
			end
		end
	endtask : axi_rd

	// config outputs lag the write edge by one clock
	task wreg(input logic [5:0] idx, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(ba(idx), d, r);
		repeat (2) @(posedge sys_clk);
	endtask : wreg

	task t_reset;
		check("pri_fmt", pc.format_sel, 2'h2);
		check("pri_bits", {pc.word_len, pc.word_bits}, 8'h98);
		check("pri_pol", {pc.frame_invert, pc.dsp_mode_b}, 2'h0);
		check("pri_bclk", {pc.bitclk_invert, sc.bitclk_invert},
			2'h0);
		check("pri_src", pc.source, 2'h1);
		check("sec_act", sc.active, 1'h0);
		check("sec_fmt", {sc.format_sel, sc.word_len}, 4'ha);
		check("sec_src", sc.source, 2'h0);
		check("dac_sel", {dr.dac1_input_sel, dr.dac2_input_sel,
			dr.dac3_input_sel, dr.dac4_input_sel}, 8'h1b);
		check("dac1_src", dr.dac1_source_sel, 2'h3);
		check("deemph", de, 4'h0);
	endtask : t_reset

	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] ad [6] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
		logic [8:0] rs [6] = '{9'h180, 9'h08a, 9'h00a, 9'h0e4, 9'h009, 9'h000};
		logic [8:0] mk [6] = '{9'h180, 9'h1bf, 9'h1ff, 9'h1ff, 9'h0ff, 9'h01f};
		for (int i = 0; i < 6; i++) begin
			axi_rd(ad[i], d, r);
			check("reset_val", d, {23'h0, rs[i]});
			axi_wr(ad[i], 32'hffff_ffff, r);
			axi_rd(ad[i], d, r);
			check("readback", d, {23'h0, mk[i]});
		end
	endtask : t_regs

	task t_aif;
		logic [5:0] bits [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
		logic [1:0] f2, w2;
		logic b4;
		for (int f = 0; f < 4; f++) begin
			for (int w = 0; w < 4; w++) begin
				f2 = f[1:0];
				w2 = w[1:0];
				b4 = f2[0] ^ w2[0];
				wreg(`ARDC_IDX_PRIMARY_TX, {23'h0, w2, f2[1], w2[0], b4, w2, f2});
				wreg(`ARDC_IDX_SECONDARY_IF, {23'h0, w2, f2[1], w2[0], b4, w2, f2});
				check("fmt", {pc.format_sel, sc.format_sel}, {f2, f2});
				check("wl", {pc.word_len, sc.word_len}, {w2, w2});
				check("pbits", pc.word_bits, bits[w2]);
				check("sbits", sc.word_bits, bits[w2]);
				check("pframe", {pc.frame_invert, pc.dsp_mode_b},
					(f2 == 2'h3) ? {1'b0, b4} : {b4, 1'b0});
				check("sframe", {sc.frame_invert, sc.dsp_mode_b},
					(f2 == 2'h3) ? {1'b0, b4} : {b4, 1'b0});
				check("bclk", {pc.bitclk_invert, sc.bitclk_invert},
					{2{w2[0]}});
				check("src", {pc.source, sc.source}, {w2, w2});
				check("active", {pc.active, sc.active}, {1'b1, f2[1]});
			end
		end
	endtask : t_aif

	task t_route;
		logic [1:0] s;
		logic m;
		for (int i = 0; i < 6; i++) begin
			s = (i < 2) ? 2'h0 : ((i < 4) ? 2'h2 : 2'h3);
			m = i[0];
			wreg(`ARDC_IDX_DAC_INPUT, {23'h0, m, m ? 8'h1b : 8'he4});
			wreg(`ARDC_IDX_DAC1_SOURCE, {23'h0, s, 7'h0});
			check("dac_sel", {dr.dac1_input_sel, dr.dac2_input_sel,
				dr.dac3_input_sel, dr.dac4_input_sel}, m ? 8'he4 : 8'h1b);
			check("dac1_src", dr.dac1_source_sel, s);
			check("rx_mode", {dr.spdif_to_dac_mode, dr.osr_from_spdif,
				dr.dacs_from_primary, dr.dac_powerdown},
				{m, s == 0 && !m, s == 0 && m, {3{s == 0 && !m}}});
		end
	endtask : t_route

	// average keeps the carry bit before halving
	function logic [23:0] pick(input logic [1:0] k);
		logic signed [24:0] sum;
		sum = {sl[23], sl} + {sr[23], sr};
		case (k)
			2'h0: return 24'h00_0000;
			2'h1: return sl;
			2'h2: return sr;
			default: return sum[24:1];
		endcase
	endfunction : pick

	task t_mix;
		for (int c = 0; c < 16; c++) begin
			wreg(`ARDC_IDX_DAC_MIX, c);
			sv <= 1;
			@(posedge sys_clk);
			sv <= 0;
			@(negedge sys_clk);
			check("mix_valid", mv, 1'h1);
			// part-select keeps the signed sample from sign-extending
			check("mix_left", ml[23:0], pick(c[1:0]));
			check("mix_right", mr[23:0], pick(c[3:2]));
		end
	endtask : t_mix

	task t_zero;
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] p, ax;
		logic [2:0] z;
		logic zx;
		for (int i = 0; i < 16; i++) begin
			z = i[3:1];
			// patterns that tell dacs 1 and 3 apart from dacs 2 and 4
			p = (z == 0) ? (i[0] ? 4'h7 : 4'hf) : (i[0] ? 4'h5 : 4'ha);
			wreg(`ARDC_IDX_DAC_MIX, {24'h0, z[0], z, 4'h9});
			dz <= p;
			repeat (2) @(posedge sys_clk);
			zx = (z == 0) ? &p : ((z < 5) ? p[z - 1] : 1'b0);
			ax = p & {4{z[0]}};
			check("zero_flag", zf, zx);
			check("automute", am, ax);
			axi_rd(8'h80, d, r);
			check("status", d, {23'h0, 3'h0, ax, 1'b1, zx});
			check("status_resp", r, 2'h0);
		end
		dz <= 4'h0;
	endtask : t_zero

	task t_deemph;
		logic [4:0] v [5] = '{5'h00, 5'h05, 5'h0a, 5'h10, 5'h13};
		for (int i = 0; i < 5; i++) begin
			wreg(`ARDC_IDX_DAC_DEEMPH, {27'h0, v[i]});
			check("deemph", de, v[i][3:0] | {4{v[i][4]}});
		end
	endtask : t_deemph

	task t_unmapped;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(8'h7c, 32'h0000_01ff, r);
		check("bresp", r, 2'h2);
		axi_rd(8'h7c, d, r);
		check("rresp", r, 2'h2);
		check("rdata", d, 32'h0000_0000);
	endtask : t_unmapped

	initial begin
		sys_clk = 0;
		sys_rst <= 1;
		{awa, ara, awv, wv, bre, arv, rre, sv, wd, dz} <= '0;
		sl <= 24'h40_0000;
		sr <= 24'ha0_0000;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 0;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_regs();
		t_aif();
		t_route();
		t_mix();
		t_zero();
		t_deemph();
		t_unmapped();
		summarize();
	end
endmodule : testbench
